// [ipw_consts.svh]
`ifndef IPW_CONSTS_SVH
`define IPW_CONSTS_SVH
`define IPW_A_TPFC 8'h88
`define IPW_A_EXFS 8'h91
`define IPW_A_WAKE 8'h9F
`define IPW_A_BPRI 8'hB8
`define IPW_A_GATEA 8'hC7
`define IPW_A_GATEB 8'hC9
`define IPW_A_EPRI 8'hF8
`define IPW_A_PROTA 8'hD0
`define IPW_RST_ZERO 8'h00
`define IPW_RST_WAKE 8'hFF
`define IPW_KEY1 8'hAA
`define IPW_KEY2 8'h55
`define IPW_CLOSE 8'h00
`define IPW_WIN_CYC 256
`define IPW_WIN_W 9
`define IPW_NSRC 15
`define IPW_SRC_W 4
`define IPW_NPIN 8
`endif

// [ipw_pkg.sv]
package ipw_pkg;
  typedef enum logic [1:0] {IPW_K_IDLE, IPW_K_HALF, IPW_K_OPEN} ipw_key_t;
  typedef struct packed {
    logic [7:0] bpri;
    logic [7:0] epri;
    logic [7:0] wake;
    logic [7:0] prota;
    logic tr1;
    logic tr0;
    logic pf1;
    logic pf0;
    logic i2cf;
    ipw_key_t ka;
    ipw_key_t kb;
    logic [8:0] wcnt;
    logic [7:0] rdata;
    logic [7:0] pin_q;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] line_s1;
    logic [7:0] line_s2;
    logic [7:0] wk_q;
    logic wake_req;
  } ipw_state_t;
endpackage

// [ipw_top.sv]
`timescale 1ns/1ps
`include "ipw_consts.svh"
// Function
// R1: base priority byte, one bit per source, bit7 unused, reset zero
// R2: extended priority byte for lines 8,7,6, watchdog, 4,3,2, i2c master
// R3: line flags in extended flag byte read-only, bit4 reads zero
// R4: line flags mirror peripheral flags directly, no latching
// R5: i2c master flag at bit0, set by hardware, cleared only by software zero
// R6: software clears timer and watchdog flags in their own peripherals
// R7: wake mask resets 0xFF, windowed-gate protected, bits enable wake sources
// R8: enabled wake event requests oscillator restart and clock resume
// R9: wake detection uses edges even for level interrupts
// R10: wake independent of interrupt enables; no vector if disabled
// R11: in stop only clockless or slow-clock sources may wake
// R12: each pin routes to gpio group 0 or 1, rising/falling/both edges
// R13: timer flags read-only, pin flags read/write, all cleared on vector entry; here ack clears only pf0 and pf1
// R14: bits 6 and 4 are timer 1 and timer 0 run enables
// R15: 0xAA then 0x55 to single-use gate grants one ticket; reads free
// R16: one protected write consumes the ticket
// R17: ticket never times out but any gate address access cancels it
// R18: single-use gate read returns unlocked state in bit 0
// R19: 0xAA then 0x55 to windowed gate opens a 256-clock window
// R20: repeating unlock before expiry restarts the full window
// R21: writing 0x00 to windowed gate closes it; read shows open in bit0
// R22: software closes both gates before idle or stop
// R23: priority bit one means high level, zero means low level
// R24: high-level pending always first; natural order breaks ties
// R25: protected write without ticket or window leaves register unchanged
module ipw_top #(
  parameter int NPIN = `IPW_NPIN
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] line_flag_i,
  input wire logic i2c_master_set_i,
  input wire logic counter0_overflow_flag_i,
  input wire logic counter1_overflow_flag_i,
  input wire logic [NPIN-1:0] gpio_pin_i,
  input wire logic [NPIN-1:0] pin_function_cfg_i,
  input wire logic [NPIN-1:0] rise_en_i,
  input wire logic [NPIN-1:0] fall_en_i,
  input wire logic [14:0] irq_enable_i,
  input wire logic ack_i,
  input wire logic [3:0] ack_src_i,
  input wire logic stop_mode_i,
  output logic irq_valid_o,
  output logic [3:0] irq_src_o,
  output logic irq_high_o,
  output logic wake_o,
  output logic counter0_run_o,
  output logic counter1_run_o,
  output logic [7:0] prot_single_o,
  output logic one_shot_unlock_flag_o,
  output logic windowed_unlock_flag_o
);
  import ipw_pkg::*;
  ipw_state_t st_ff, nxt_st;
  logic [14:0] pend;
  logic [14:0] lvl;
  logic [1:0] grp_evt;
  logic [7:0] line_v;
  logic found;
  // ****************************************
  // source vector, natural order index 0..14
  // ****************************************
  // line_flag_i: bit0 unused,1 line2,2 line3,3 line4,4 watchdog,5 line6,6 line7,7 line8
  assign line_v = st_ff.line_s2;
  always_comb begin
    pend = {line_v[7], line_v[6], line_v[5], line_v[4], line_v[3], line_v[2], line_v[1],
      st_ff.i2cf, 1'b0, 1'b0, 1'b0, counter1_overflow_flag_i, st_ff.pf1,
      counter0_overflow_flag_i, st_ff.pf0} & irq_enable_i;
    // uart and timer2 flags live elsewhere; their level bits still exist
    lvl = {st_ff.epri[7:1], st_ff.epri[0], st_ff.bpri[6:0]}; // [R23]
  end
  // ****************************************
  // two-level arbitration
  // ****************************************
  always_comb begin
    found = 1'b0;
    irq_src_o = 4'h0;
    irq_high_o = 1'b0;
    for (int i = 0; i < `IPW_NSRC; i++) begin
      if (!found && pend[i] && lvl[i]) begin // [R24]
        found = 1'b1;
        irq_src_o = i[3:0];
        irq_high_o = 1'b1;
      end
    end
    for (int i = 0; i < `IPW_NSRC; i++) begin
      if (!found && pend[i]) begin // [R24]
        found = 1'b1;
        irq_src_o = i[3:0];
      end
    end
    irq_valid_o = found;
  end
  // ****************************************
  // gpio grouping and edges
  // ****************************************
  always_comb begin
    grp_evt = 2'h0;
    for (int p = 0; p < NPIN; p++) begin
      if ((rise_en_i[p] && st_ff.pin_s2[p] && !st_ff.pin_q[p]) ||
          (fall_en_i[p] && !st_ff.pin_s2[p] && st_ff.pin_q[p])) begin // [R12]
        grp_evt[pin_function_cfg_i[p]] = 1'b1;
      end
    end
  end
  // single decode of the ticket-protected address, shared by the checks below
  function automatic logic is_prot_a(input logic [7:0] a);
    return a == `IPW_A_PROTA;
  endfunction
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] wk;
    logic tb_open;
    wk = {line_v[7], line_v[6], line_v[5], line_v[3], line_v[2], line_v[1], 1'b0, 1'b0};
    tb_open = (st_ff.kb == IPW_K_OPEN);
    nxt_st = st_ff;
    nxt_st.pin_s1 = gpio_pin_i;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.pin_q = st_ff.pin_s2;
    nxt_st.line_s1 = line_flag_i;
    nxt_st.line_s2 = st_ff.line_s1; // [R4]
    nxt_st.wk_q = wk;
    // wake edges are seen even with the interrupt disabled [R10]
    nxt_st.wake_req = stop_mode_i && (|(st_ff.wake & (({wk[7:2], 2'b00} & ~st_ff.wk_q)
      | {6'h00, grp_evt}))); // [R8] [R9] [R11]
    nxt_st.rdata = `IPW_RST_ZERO;
    if (tb_open) begin
      if (st_ff.wcnt == `IPW_WIN_W'(`IPW_WIN_CYC - 1)) begin
        nxt_st.kb = IPW_K_IDLE; // [R19]
        nxt_st.wcnt = '0;
      end else begin
        nxt_st.wcnt = st_ff.wcnt + `IPW_WIN_W'(1);
      end
    end
    if (wr_i) begin
      unique case (addr_i)
        `IPW_A_BPRI: nxt_st.bpri = {1'b0, wdata_i[6:0]}; // [R1]
        `IPW_A_EPRI: nxt_st.epri = wdata_i; // [R2]
        `IPW_A_EXFS: if (!wdata_i[0]) nxt_st.i2cf = 1'b0; // [R3] [R5]
        `IPW_A_WAKE: if (tb_open) nxt_st.wake = wdata_i; // [R7] [R25]
        `IPW_A_TPFC: begin
          nxt_st.tr1 = wdata_i[6]; // [R14]
          nxt_st.tr0 = wdata_i[4];
          nxt_st.pf1 = wdata_i[3]; // [R13]
          nxt_st.pf0 = wdata_i[1];
        end
        `IPW_A_GATEA: begin
          if (st_ff.ka == IPW_K_IDLE && wdata_i == `IPW_KEY1) nxt_st.ka = IPW_K_HALF; // [R15]
          else if (st_ff.ka == IPW_K_HALF && wdata_i == `IPW_KEY2) nxt_st.ka = IPW_K_OPEN;
          else nxt_st.ka = IPW_K_IDLE; // [R17]
        end
        `IPW_A_GATEB: begin
          if (wdata_i == `IPW_CLOSE) begin
            nxt_st.kb = IPW_K_IDLE; // [R21]
            nxt_st.wcnt = '0;
          end else if (wdata_i == `IPW_KEY1) begin
            if (!tb_open) nxt_st.kb = IPW_K_HALF;
          end else if (wdata_i == `IPW_KEY2 && st_ff.kb == IPW_K_HALF) begin
            nxt_st.kb = IPW_K_OPEN; // [R19]
            nxt_st.wcnt = '0;
          end else if (wdata_i == `IPW_KEY2 && tb_open) begin
            // restart must also beat the expiry of the last window cycle
            nxt_st.kb = IPW_K_OPEN; // [R20]
            nxt_st.wcnt = '0; // [R20]
          end else if (!tb_open) begin
            nxt_st.kb = IPW_K_IDLE;
          end
        end
        `IPW_A_PROTA: begin
          if (st_ff.ka == IPW_K_OPEN) begin
            nxt_st.prota = wdata_i; // [R25]
            nxt_st.ka = IPW_K_IDLE; // [R16]
          end
        end
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        `IPW_A_BPRI: nxt_st.rdata = st_ff.bpri;
        `IPW_A_EPRI: nxt_st.rdata = st_ff.epri;
        `IPW_A_EXFS: nxt_st.rdata = {line_v[7:5], 1'b0, line_v[3:1], st_ff.i2cf}; // [R3]
        `IPW_A_WAKE: nxt_st.rdata = st_ff.wake;
        `IPW_A_TPFC: nxt_st.rdata = {counter1_overflow_flag_i, st_ff.tr1,
          counter0_overflow_flag_i, st_ff.tr0, st_ff.pf1, 1'b0, st_ff.pf0, 1'b0};
        `IPW_A_GATEA: begin
          nxt_st.rdata = {7'h00, st_ff.ka == IPW_K_OPEN}; // [R18]
          nxt_st.ka = IPW_K_IDLE; // [R17]
        end
        `IPW_A_GATEB: nxt_st.rdata = {7'h00, tb_open}; // [R21]
        `IPW_A_PROTA: nxt_st.rdata = st_ff.prota; // [R15]
        default: nxt_st.rdata = `IPW_RST_ZERO;
      endcase
    end
    if (ack_i && ack_src_i == 4'h0) nxt_st.pf0 = 1'b0; // [R13]
    if (ack_i && ack_src_i == 4'h2) nxt_st.pf1 = 1'b0; // [R13]
    // hardware set beats software clear
    if (grp_evt[0]) nxt_st.pf0 = 1'b1;
    if (grp_evt[1]) nxt_st.pf1 = 1'b1;
    if (i2c_master_set_i) nxt_st.i2cf = 1'b1; // [R5]
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
      st_ff.wake <= `IPW_RST_WAKE; // [R7]
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign rdata_o = st_ff.rdata;
  assign wake_o = st_ff.wake_req;
  assign counter0_run_o = st_ff.tr0;
  assign counter1_run_o = st_ff.tr1;
  assign prot_single_o = st_ff.prota;
  assign one_shot_unlock_flag_o = (st_ff.ka == IPW_K_OPEN);
  assign windowed_unlock_flag_o = (st_ff.kb == IPW_K_OPEN);
  // ****************************************
  // checks
  // ****************************************
  a_wake_ro: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R25]
    (wr_i && addr_i == `IPW_A_WAKE && !windowed_unlock_flag_o) |=> $stable(st_ff.wake))
    else $error("wake mask changed while gate closed");
  a_ticket_use: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R16]
    (wr_i && is_prot_a(addr_i) && one_shot_unlock_flag_o) |=> !one_shot_unlock_flag_o)
    else $error("ticket not consumed");
  a_gate_close: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R21]
    (wr_i && addr_i == `IPW_A_GATEB && wdata_i == `IPW_CLOSE) |=> !windowed_unlock_flag_o)
    else $error("window not closed");
  a_win_len: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R19]
    $rose(windowed_unlock_flag_o) && !wr_i |-> st_ff.wcnt == 9'h000)
    else $error("window count not restarted");
  a_hi_first: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R24]
    (|(pend & lvl)) |-> irq_high_o && irq_valid_o)
    else $error("low level served before high");
  a_i2c_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
    (st_ff.i2cf && !(wr_i && addr_i == `IPW_A_EXFS && !wdata_i[0])) |=> st_ff.i2cf)
    else $error("i2c flag lost");
  a_rd_gatea: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R18]
    (rd_i && addr_i == `IPW_A_GATEA) |=> rdata_o == {7'h00, $past(one_shot_unlock_flag_o)})
    else $error("gate status readback wrong");
  a_bpri_b7: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R1]
    !st_ff.bpri[7])
    else $error("unused priority bit set");
  // ****************************************
  // register and arbitration checks
  // ****************************************
  a_bpri_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R1]
    (wr_i && addr_i == `IPW_A_BPRI) |=> st_ff.bpri[6:0] == $past(wdata_i[6:0]))
    else $error("base priority write lost");
  a_epri_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R2]
    (wr_i && addr_i == `IPW_A_EPRI) |=> st_ff.epri == $past(wdata_i))
    else $error("extended priority write lost");
  a_line_mirror: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R4]
    line_v == $past(line_flag_i, 2))
    else $error("line flags not mirrored");
  a_exfs_b4: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R3]
    (rd_i && addr_i == `IPW_A_EXFS) |=> !rdata_o[4])
    else $error("unused flag bit reads one");
  a_exfs_lines: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R3] [R4]
    (rd_i && addr_i == `IPW_A_EXFS) |=> rdata_o[7:5] == $past(line_v[7:5]))
    else $error("line flag readback wrong");
  a_i2c_set: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
    i2c_master_set_i |=> st_ff.i2cf)
    else $error("i2c flag not set");
  a_i2c_clr: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R5]
    (wr_i && addr_i == `IPW_A_EXFS && !wdata_i[0] && !i2c_master_set_i) |=> !st_ff.i2cf)
    else $error("i2c flag not cleared");
  a_tpfc_flags: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R13]
    (rd_i && addr_i == `IPW_A_TPFC) |=> rdata_o[7] == $past(counter1_overflow_flag_i)
      && rdata_o[5] == $past(counter0_overflow_flag_i))
    else $error("overflow flag readback wrong");
  a_tpfc_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R13]
    (rd_i && addr_i == `IPW_A_TPFC) |=> !rdata_o[2] && !rdata_o[0])
    else $error("unused control bits read one");
  a_run_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R14]
    (wr_i && addr_i == `IPW_A_TPFC) |=> counter1_run_o == $past(wdata_i[6])
      && counter0_run_o == $past(wdata_i[4]))
    else $error("run enable write lost");
  a_ack_pf0: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R13]
    (ack_i && ack_src_i == 4'h0 && !grp_evt[0]) |=> !st_ff.pf0)
    else $error("group0 flag kept on vector entry");
  a_ack_pf1: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R13]
    (ack_i && ack_src_i == 4'h2 && !grp_evt[1]) |=> !st_ff.pf1)
    else $error("group1 flag kept on vector entry");
  a_pin_set: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12]
    grp_evt[0] |=> st_ff.pf0)
    else $error("pin edge lost");
  a_rd_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R21]
    !rd_i |=> rdata_o == `IPW_RST_ZERO)
    else $error("read data outside read slot");
  a_src_valid: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R24]
    irq_valid_o |-> pend[irq_src_o])
    else $error("vector to idle source");
  a_no_pend: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R24]
    !(|pend) |-> !irq_valid_o)
    else $error("request without pending source");
  a_lo_level: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R23]
    (irq_valid_o && !irq_high_o) |-> !lvl[irq_src_o])
    else $error("high source shown as low");
  a_tie_order: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R24]
    irq_valid_o |-> (pend & (irq_high_o ? lvl : 15'h7FFF)
      & ((15'h0001 << irq_src_o) - 15'h0001)) == 15'h0000)
    else $error("natural order broken");
  // ****************************************
  // wake checks
  // ****************************************
  a_wake_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R7]
    (wr_i && addr_i == `IPW_A_WAKE && windowed_unlock_flag_o) |=> st_ff.wake == $past(wdata_i))
    else $error("wake mask write lost");
  a_wake_run: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R11]
    !stop_mode_i |=> !wake_o)
    else $error("wake outside stop");
  a_mask_off: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R7]
    (st_ff.wake == 8'h00) |=> !wake_o)
    else $error("masked wake");
  a_wake_grp: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12] [R9]
    (stop_mode_i && |(grp_evt & st_ff.wake[1:0])) |=> wake_o)
    else $error("pin wake lost");
  a_wake_l8: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R8] [R10]
    ($rose(line_v[7]) && stop_mode_i && st_ff.wake[7]) |=> wake_o)
    else $error("line8 wake lost");
  a_wake_l2: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R8] [R9]
    ($rose(line_v[1]) && stop_mode_i && st_ff.wake[2]) |=> wake_o)
    else $error("line2 wake lost");
  // a held level must not keep waking, or the core would never stay stopped
  a_wake_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R9]
    (stop_mode_i && $stable(line_v) && grp_evt == 2'b00) |=> !wake_o)
    else $error("wake on level");
  // ****************************************
  // gate checks
  // ****************************************
  sequence s_key_a1;
    wr_i && addr_i == `IPW_A_GATEA && wdata_i == `IPW_KEY1 && st_ff.ka == IPW_K_IDLE;
  endsequence
  sequence s_key_a2;
    wr_i && addr_i == `IPW_A_GATEA && wdata_i == `IPW_KEY2 && st_ff.ka == IPW_K_HALF;
  endsequence
  sequence s_key_b2;
    wr_i && addr_i == `IPW_A_GATEB && wdata_i == `IPW_KEY2 && st_ff.kb == IPW_K_HALF;
  endsequence
  a_key_half: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R15]
    s_key_a1 |=> st_ff.ka == IPW_K_HALF)
    else $error("first key not taken");
  a_key_open: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R15]
    s_key_a2 |=> one_shot_unlock_flag_o)
    else $error("ticket not granted");
  a_ta_rdcan: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R17]
    (rd_i && addr_i == `IPW_A_GATEA) |=> !one_shot_unlock_flag_o)
    else $error("gate read left ticket");
  a_ta_wrcan: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R17]
    (wr_i && addr_i == `IPW_A_GATEA && wdata_i != `IPW_KEY2) |=> !one_shot_unlock_flag_o)
    else $error("gate write left ticket");
  a_ta_noexp: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R17]
    (one_shot_unlock_flag_o && !wr_i && !rd_i) |=> one_shot_unlock_flag_o)
    else $error("ticket expired");
  a_prot_keep: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R25]
    (wr_i && is_prot_a(addr_i) && !one_shot_unlock_flag_o) |=> $stable(prot_single_o))
    else $error("protected write without ticket");
  a_prot_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R16]
    (wr_i && is_prot_a(addr_i) && one_shot_unlock_flag_o) |=> prot_single_o == $past(wdata_i))
    else $error("ticketed write lost");
  a_tb_open: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R19]
    s_key_b2 |=> windowed_unlock_flag_o && st_ff.wcnt == 9'h000)
    else $error("window not opened");
  a_tb_restart: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R20]
    (windowed_unlock_flag_o && wr_i && addr_i == `IPW_A_GATEB && wdata_i == `IPW_KEY2)
      |=> windowed_unlock_flag_o && st_ff.wcnt == 9'h000)
    else $error("window not restarted");
  a_tb_end: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R19]
    (windowed_unlock_flag_o && st_ff.wcnt == `IPW_WIN_W'(`IPW_WIN_CYC - 1)
      && !(wr_i && addr_i == `IPW_A_GATEB)) |=> !windowed_unlock_flag_o)
    else $error("window outlived its length");
  a_tb_stay: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R19]
    (windowed_unlock_flag_o && st_ff.wcnt != `IPW_WIN_W'(`IPW_WIN_CYC - 1)
      && !(wr_i && addr_i == `IPW_A_GATEB))
      |=> windowed_unlock_flag_o && st_ff.wcnt == $past(st_ff.wcnt) + `IPW_WIN_W'(1))
    else $error("window closed early");
  a_tb_rd: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R21]
    (rd_i && addr_i == `IPW_A_GATEB) |=> rdata_o == {7'h00, $past(windowed_unlock_flag_o)})
    else $error("window status readback wrong");
endmodule // ipw_top

// [ipw_partner.sv]
`timescale 1ns/1ps
// ****************
// peripheral side
// ****************
module ipw_partner (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] flag_set_i,
  input wire logic i2c_go_i,
  output logic [7:0] line_flag_o,
  output logic i2c_master_set_o
);
  // flags follow flag_set_i one cycle later with bit0 forced to zero; nothing holds them here
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_flag_o <= 8'h00;
      i2c_master_set_o <= 1'b0;
    end else begin
      line_flag_o <= flag_set_i & 8'hFE;
      i2c_master_set_o <= i2c_go_i;
    end
  end
endmodule // ipw_partner

// [test_ipw_top.sv]
`timescale 1ns/1ps
module test_ipw_top;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, i2c_go = 1'b0, stop = 1'b0;
  logic c0f = 1'b0, c1f = 1'b0, ack = 1'b0, i2cs, iv, ih, wk, r0, r1, fa, fb;
  logic [7:0] addr = 8'h00, wdata = 8'h00, fset = 8'h00, pin = 8'h00, cfg = 8'h00;
  logic [7:0] rise = 8'h00, fall = 8'h00, lf, rdata, prot, d, v;
  logic [14:0] ien = 15'h7FFF;
  logic [3:0] asrc = 4'h0, src;
  int err_count = 0, checks = 0, seed = 25098;
  always #2 clk = ~clk;
  ipw_partner ipw_partner_i (.clk_i(clk), .arst_n_i(arst_n), .flag_set_i(fset),
    .i2c_go_i(i2c_go), .line_flag_o(lf), .i2c_master_set_o(i2cs));
  ipw_top ipw_top_i (.clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .line_flag_i(lf), .i2c_master_set_i(i2cs),
    .counter0_overflow_flag_i(c0f), .counter1_overflow_flag_i(c1f), .gpio_pin_i(pin),
    .pin_function_cfg_i(cfg), .rise_en_i(rise), .fall_en_i(fall), .irq_enable_i(ien),
    .ack_i(ack), .ack_src_i(asrc), .stop_mode_i(stop), .irq_valid_o(iv),
    .irq_src_o(src), .irq_high_o(ih), .wake_o(wk), .counter0_run_o(r0),
    .counter1_run_o(r1), .prot_single_o(prot), .one_shot_unlock_flag_o(fa),
    .windowed_unlock_flag_o(fb));
  // ****************
  // bus and checks
  // ****************
  task automatic print_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd8(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic key(input logic [7:0] a);
    wr8(a, 8'hAA);
    wr8(a, 8'h55);
  endtask
  initial begin
    #(4 * 6000);
    err_count++;
    print_verdict();
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rd8(8'h88); chk("tpfc", 8'h00, d);
    rd8(8'h91); chk("exfs", 8'h00, d);
    rd8(8'h9F); chk("wake", 8'hFF, d);
    rd8(8'hB8); chk("bpri", 8'h00, d);
    rd8(8'hF8); chk("epri", 8'h00, d);
    rd8(8'hC9); chk("gateb", 8'h00, d);
    rd8(8'h42); chk("unmapped", 8'h00, d);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      wr8(8'hB8, v);
      rd8(8'hB8); chk("bpri", v & 8'h7F, d);
      wr8(8'hF8, ~v);
      rd8(8'hF8); chk("epri", ~v, d);
      fset <= 8'($random(seed));
      cyc(4);
      wr8(8'h91, 8'hFE);
      rd8(8'h91); chk("exfs", fset & 8'hEE, d);
    end
    fset <= 8'h00;
    i2c_go <= 1'b1;
    @(posedge clk);
    i2c_go <= 1'b0;
    cyc(4);
    rd8(8'h91); chk("i2cf", 8'h01, d);
    wr8(8'h91, 8'h00);
    rd8(8'h91); chk("i2cf", 8'h00, d);
    fset <= 8'hE0;
    wr8(8'hF8, 8'h00);
    cyc(4);
    chk("src", 8'd12, {4'h0, src});
    chk("high", 8'h00, {7'h0, ih});
    wr8(8'hF8, 8'h80);
    cyc(1);
    chk("src", 8'd14, {4'h0, src});
    chk("high", 8'h01, {7'h0, ih & iv});
    ien <= 15'h3FFF;
    cyc(1);
    chk("src", 8'd12, {4'h0, src});
    fset <= 8'h00;
    c0f <= 1'b1;
    c1f <= 1'b1;
    wr8(8'h88, 8'h50);
    rd8(8'h88); chk("tpfc", 8'hF0, d);
    chk("run", 8'h03, {6'h0, r1, r0});
    wr8(8'h88, 8'h0A);
    rd8(8'h88); chk("tpfc", 8'hAA, d);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    c0f <= 1'b0;
    c1f <= 1'b0;
    rd8(8'h88); chk("tpfc", 8'h08, d);
    wr8(8'hD0, 8'h5A);
    cyc(1); chk("prot", 8'h00, prot);
    key(8'hC7);
    cyc(1); chk("one_shot_unlock_flag", 8'h01, {7'h0, fa});
    wr8(8'hD0, 8'h5A);
    cyc(1); chk("prot", 8'h5A, prot);
    chk("one_shot_unlock_flag", 8'h00, {7'h0, fa});
    wr8(8'hD0, 8'h33);
    cyc(1); chk("prot", 8'h5A, prot);
    key(8'hC7);
    rd8(8'hC7); chk("one_shot_unlock_flag", 8'h01, d);
    wr8(8'hD0, 8'h33);
    cyc(1); chk("prot", 8'h5A, prot);
    wr8(8'h9F, 8'h01);
    rd8(8'h9F); chk("wake", 8'hFF, d);
    key(8'hC9);
    wr8(8'h9F, 8'h01);
    rd8(8'h9F); chk("wake", 8'h01, d);
    rd8(8'hC9); chk("gateb", 8'h01, d);
    cyc(240); chk("windowed_unlock_flag", 8'h01, {7'h0, fb});
    cyc(20); chk("windowed_unlock_flag", 8'h00, {7'h0, fb});
    key(8'hC9);
    cyc(200);
    key(8'hC9);
    cyc(200); chk("windowed_unlock_flag", 8'h01, {7'h0, fb});
    wr8(8'hC9, 8'h00);
    cyc(1); chk("windowed_unlock_flag", 8'h00, {7'h0, fb});
    stop <= 1'b1;
    rise <= 8'hFF;
    cfg <= 8'h02;
    cyc(2);
    pin <= 8'h02;
    cyc(8); chk("wake", 8'h00, {7'h0, wk});
    pin <= 8'h03;
    for (int i = 0; i < 10 && wk !== 1'b1; i++) cyc(1);
    chk("wake", 8'h01, {7'h0, wk});
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    rd8(8'h9F); chk("wake", 8'hFF, d);
    rd8(8'hC9); chk("gateb", 8'h00, d);
    print_verdict();
  end
endmodule // test_ipw_top
